// ---- common/idb_pkg.sv ----
// Constants and types shared by the inductive button detector
package idb_pkg;
   localparam int NCH = 4;
   localparam int VW = 32;

   // Register offsets
   localparam logic [7:0] OFS_BUTTON_STATUS = 8'h01;
   localparam logic [7:0] OFS_CHANNEL_ENABLE = 8'h0c;
   localparam logic [7:0] OFS_LOW_STEP = 8'h13;
   localparam logic [7:0] OFS_NORMAL_STEP = 8'h15;
   localparam logic [7:0] OFS_HOLD_STRONGEST = 8'h16;
   localparam logic [7:0] OFS_HYSTERESIS = 8'h18;
   localparam logic [7:0] OFS_TORSION = 8'h19;
   localparam logic [7:0] OFS_SHARED_BEND = 8'h1a;
   localparam logic [7:0] OFS_SCALER = 8'h1e;
   localparam logic [7:0] OFS_QUICK_CH0 = 8'h25;
   localparam logic [7:0] OFS_QUICK_CH1_CH2 = 8'h28;
   localparam logic [7:0] OFS_QUICK_CH3 = 8'h2b;

   // Field positions
   localparam int STEP_IDX_LSB = 0;
   localparam int STEP_IDX_W = 4;
   localparam int STRONGEST_LSB = 0;
   localparam int HOLD_LSB = 4;
   localparam int SHARED_LSB = 0;
   localparam int BEND_LSB = 4;
   localparam int TORSION_EN_BIT = 7;
   localparam int TORSION_THR_LSB = 0;
   localparam int TORSION_THR_W = 7;
   localparam int SCALER_W = 2;
   localparam int QUICK_W = 2;
   localparam int QUICK_CH2_LSB = 2;

   // Reset values
   localparam logic [7:0] RST_HYSTERESIS = 8'h20;
   localparam logic [7:0] RST_CHANNEL_ENABLE = 8'h0f;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // Arithmetic constants: values are held 72 times larger so that both
   // step divisors (72 and 9) become exact integers
   localparam logic [VW-1:0] NOMINAL_THRESHOLD = 32'h0000_0080;
   localparam logic [VW-1:0] VALUE_SCALE = 32'h0000_0048;
   localparam int LOW_MODE_SHIFT = 3;

   typedef enum logic [0:0] {
      IDB_IDLE,
      IDB_EVAL
   } idb_phase_t;

   typedef struct packed {
      logic [7:0] chan_en;
      logic [7:0] low_idx;
      logic [7:0] normal_idx;
      logic [7:0] hold_strongest;
      logic [7:0] hysteresis;
      logic [7:0] torsion;
      logic [7:0] shared_bend;
      logic [7:0] scaler;
      logic [7:0] quick0;
      logic [7:0] quick12;
      logic [7:0] quick3;
      logic [NCH-1:0] button;
      logic [NCH-1:0] primed;
      logic [NCH-1:0][VW-1:0] baseline;
      logic [NCH-1:0][VW-1:0] value;
      logic [7:0] rdata;
      idb_phase_t phase;
   } idb_state_t;
endpackage : idb_pkg

// ---- core/idb_detector.sv ----
// Per-channel threshold, baseline tracking and group filtering of button samples
// Overview of operation
// - Hysteresis register holds 32 after reset, applied equally around threshold 128.
// - Channel becomes pressed once its value reaches 128 plus hysteresis.
// - Pressed channel releases once value falls to 128 minus hysteresis, or when a group or torsion filter suppresses it.
// - Normal mode baseline step per scan is two to the normal index, over 72.
// - Low mode baseline step per scan is two to the low index, over 9.
// - Tracking baseline makes a steady press release after a bounded number of scans.
// - With hold bit set, baseline freezes while that channel output is asserted.
// - Negative value multiplies step by quick factor 1, 4, 8 or 16.
// - Shared-response group members all suppressed when several respond together.
// - Strongest group reports only the channel with the largest value.
// - Torsion guard suppresses all presses while any enabled channel's value is below negative limit.
// - Bend group suppresses a member when another member responds twice as strongly.
// - Outputs and interrupt change at end of the window after press or release.
`timescale 1ns/100ps
`default_nettype none
module idb_detector (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic normal_power_i,
   input wire logic sample_valid_i,
   input wire logic [1:0] sample_channel_i,
   input wire logic [15:0] sample_count_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_write_i,
   output logic [7:0] reg_rdata_o,
   output logic [idb_pkg::NCH-1:0] channel_button_output_o,
   output logic interrupt_output_o,
   output logic [idb_pkg::NCH-1:0][idb_pkg::VW-1:0] channel_processed_value_o
);
   idb_pkg::idb_state_t s_q;
   idb_pkg::idb_state_t s_d;
   idb_pkg::idb_state_t reset_state;

   logic [idb_pkg::VW-1:0] scaled;
   logic signed [idb_pkg::VW-1:0] signal;
   logic signed [idb_pkg::VW-1:0] diff;
   logic signed [idb_pkg::VW-1:0] step;
   logic signed [idb_pkg::VW-1:0] quick_step;
   logic signed [idb_pkg::VW-1:0] on_level;
   logic signed [idb_pkg::VW-1:0] off_level;
   logic signed [idb_pkg::VW-1:0] torsion_level;
   logic [idb_pkg::NCH-1:0] cand;
   logic [idb_pkg::NCH-1:0] bend_keep;
   logic [idb_pkg::NCH-1:0] strong_keep;
   logic [1:0] scale_sel;
   logic [1:0] quick_sel;
   logic [2:0] shared_cnt;
   logic twisted;
   int ch;

   // Quick factor code to a shift: 1, 4, 8, 16
   function automatic logic [2:0] quick_shift(input logic [1:0] code);
      logic [2:0] r;
      r = 3'h0;
      case (code)
         2'h0: r = 3'h0;
         2'h1: r = 3'h2;
         2'h2: r = 3'h3;
         default: r = 3'h4;
      endcase
      return r;
   endfunction : quick_shift

   always_comb begin
      reset_state = '0;
      reset_state.chan_en = idb_pkg::RST_CHANNEL_ENABLE;
      reset_state.hysteresis = idb_pkg::RST_HYSTERESIS;
      reset_state.phase = idb_pkg::IDB_IDLE;
   end

   always_comb begin
      s_d = s_q;
      ch = int'(sample_channel_i);
      scale_sel = 2'h0;
      quick_sel = 2'h0;
      scaled = '0;
      signal = '0;
      diff = '0;
      step = '0;
      quick_step = '0;
      on_level = '0;
      off_level = '0;
      torsion_level = '0;
      cand = '0;
      bend_keep = '0;
      strong_keep = '0;
      shared_cnt = 3'h0;
      twisted = 1'b0;

      // Register writes
      if (reg_write_i) begin
         case (reg_addr_i)
            idb_pkg::OFS_CHANNEL_ENABLE: s_d.chan_en = reg_wdata_i;
            idb_pkg::OFS_LOW_STEP: s_d.low_idx = reg_wdata_i;
            idb_pkg::OFS_NORMAL_STEP: s_d.normal_idx = reg_wdata_i;
            idb_pkg::OFS_HOLD_STRONGEST: s_d.hold_strongest = reg_wdata_i;
            idb_pkg::OFS_HYSTERESIS: s_d.hysteresis = reg_wdata_i;
            idb_pkg::OFS_TORSION: s_d.torsion = reg_wdata_i;
            idb_pkg::OFS_SHARED_BEND: s_d.shared_bend = reg_wdata_i;
            idb_pkg::OFS_SCALER: s_d.scaler = reg_wdata_i;
            idb_pkg::OFS_QUICK_CH0: s_d.quick0 = reg_wdata_i;
            idb_pkg::OFS_QUICK_CH1_CH2: s_d.quick12 = reg_wdata_i;
            idb_pkg::OFS_QUICK_CH3: s_d.quick3 = reg_wdata_i;
            default: ;
         endcase
      end

      // Read data registered; unmapped offsets read zero
      case (reg_addr_i)
         idb_pkg::OFS_BUTTON_STATUS: s_d.rdata = {4'h0, s_q.button};
         idb_pkg::OFS_CHANNEL_ENABLE: s_d.rdata = s_q.chan_en;
         idb_pkg::OFS_LOW_STEP: s_d.rdata = s_q.low_idx;
         idb_pkg::OFS_NORMAL_STEP: s_d.rdata = s_q.normal_idx;
         idb_pkg::OFS_HOLD_STRONGEST: s_d.rdata = s_q.hold_strongest;
         idb_pkg::OFS_HYSTERESIS: s_d.rdata = s_q.hysteresis;
         idb_pkg::OFS_TORSION: s_d.rdata = s_q.torsion;
         idb_pkg::OFS_SHARED_BEND: s_d.rdata = s_q.shared_bend;
         idb_pkg::OFS_SCALER: s_d.rdata = s_q.scaler;
         idb_pkg::OFS_QUICK_CH0: s_d.rdata = s_q.quick0;
         idb_pkg::OFS_QUICK_CH1_CH2: s_d.rdata = s_q.quick12;
         idb_pkg::OFS_QUICK_CH3: s_d.rdata = s_q.quick3;
         default: s_d.rdata = 8'h00;
      endcase

      case (s_q.phase)
         idb_pkg::IDB_IDLE: begin
            if (sample_valid_i && s_q.chan_en[ch]) begin
               // Host-programmed scaler keeps the count in range
               scale_sel = s_q.scaler[ch*idb_pkg::SCALER_W +: idb_pkg::SCALER_W];
               scaled = {16'h0000, sample_count_i >> scale_sel};
               signal = $signed(scaled * idb_pkg::VALUE_SCALE);
               diff = signal - $signed(s_q.baseline[ch]);
               if (normal_power_i) begin
                  step = $signed(32'h1 << s_q.normal_idx[idb_pkg::STEP_IDX_W-1:0]);
               end else begin
                  step = $signed(32'h1 << (5'(s_q.low_idx[idb_pkg::STEP_IDX_W-1:0])
                                          + 5'(idb_pkg::LOW_MODE_SHIFT)));
               end
               case (ch)
                  0: quick_sel = s_q.quick0[idb_pkg::QUICK_W-1:0];
                  1: quick_sel = s_q.quick12[idb_pkg::QUICK_W-1:0];
                  2: quick_sel = s_q.quick12[idb_pkg::QUICK_CH2_LSB +: idb_pkg::QUICK_W];
                  default: quick_sel = s_q.quick3[idb_pkg::QUICK_W-1:0];
               endcase
               quick_step = step <<< quick_shift(quick_sel);
               if (!s_q.primed[ch]) begin
                  // First sample after reset seeds the baseline
                  s_d.baseline[ch] = signal;
                  s_d.primed[ch] = 1'b1;
                  s_d.value[ch] = '0;
               end else begin
                  s_d.value[ch] = diff;
                  if (!(s_q.hold_strongest[idb_pkg::HOLD_LSB + ch] && s_q.button[ch])) begin
                     // Baseline creeps toward the signal, so a steady press fades
                     if (diff >= 0) begin
                        s_d.baseline[ch] = $signed(s_q.baseline[ch])
                                         + ((diff > step) ? step : diff);
                     end else begin
                        s_d.baseline[ch] = $signed(s_q.baseline[ch])
                                         - ((-diff > quick_step) ? quick_step : -diff);
                     end
                  end
               end
               s_d.phase = idb_pkg::IDB_EVAL;
            end
         end
         idb_pkg::IDB_EVAL: begin
            on_level = $signed((idb_pkg::NOMINAL_THRESHOLD + 32'(s_q.hysteresis))
                               * idb_pkg::VALUE_SCALE);
            off_level = $signed((idb_pkg::NOMINAL_THRESHOLD - 32'(s_q.hysteresis))
                                * idb_pkg::VALUE_SCALE);
            torsion_level = -$signed(32'(s_q.torsion[idb_pkg::TORSION_THR_LSB +:
                                         idb_pkg::TORSION_THR_W]) * idb_pkg::VALUE_SCALE);
            for (int n = 0; n < idb_pkg::NCH; n++) begin
               if (s_q.chan_en[n] && s_q.primed[n]) begin
                  if (s_q.button[n]) begin
                     cand[n] = $signed(s_q.value[n]) > off_level;
                  end else begin
                     cand[n] = $signed(s_q.value[n]) >= on_level;
                  end
                  if ($signed(s_q.value[n]) < torsion_level) begin
                     twisted = 1'b1;
                  end
               end
            end
            // Bend group: a member yields to a neighbour twice as strong
            bend_keep = cand;
            for (int n = 0; n < idb_pkg::NCH; n++) begin
               for (int m = 0; m < idb_pkg::NCH; m++) begin
                  if (m != n && s_q.shared_bend[idb_pkg::BEND_LSB + n]
                      && s_q.shared_bend[idb_pkg::BEND_LSB + m] && s_q.chan_en[m]
                      && $signed(s_q.value[m]) > ($signed(s_q.value[n]) <<< 1)) begin
                     bend_keep[n] = 1'b0;
                  end
               end
            end
            for (int n = 0; n < idb_pkg::NCH; n++) begin
               if (bend_keep[n] && s_q.shared_bend[idb_pkg::SHARED_LSB + n]) begin
                  shared_cnt = shared_cnt + 3'h1;
               end
            end
            strong_keep = bend_keep;
            if (shared_cnt > 3'h1) begin
               // Press between buttons: a common response on several is not a press
               strong_keep = bend_keep & ~s_q.shared_bend[idb_pkg::SHARED_LSB +: idb_pkg::NCH];
            end
            cand = strong_keep;
            for (int n = 0; n < idb_pkg::NCH; n++) begin
               for (int m = 0; m < idb_pkg::NCH; m++) begin
                  if (m != n && strong_keep[n] && strong_keep[m]
                      && s_q.hold_strongest[idb_pkg::STRONGEST_LSB + n]
                      && s_q.hold_strongest[idb_pkg::STRONGEST_LSB + m]
                      && ($signed(s_q.value[m]) > $signed(s_q.value[n])
                          || ($signed(s_q.value[m]) == $signed(s_q.value[n]) && m < n))) begin
                     cand[n] = 1'b0;
                  end
               end
            end
            if (s_q.torsion[idb_pkg::TORSION_EN_BIT] && twisted) begin
               cand = '0;
            end
            s_d.button = cand;
            s_d.phase = idb_pkg::IDB_IDLE;
         end
         default: s_d.phase = idb_pkg::IDB_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_q <= reset_state;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_o = s_q.rdata;
   assign channel_button_output_o = s_q.button;
   assign interrupt_output_o = |s_q.button;
   assign channel_processed_value_o = s_q.value;
endmodule : idb_detector
`default_nettype wire

// ---- tb/idb_detector_asserts.sv ----
// Port-level checker for the inductive button detector
`timescale 1ns/100ps
`default_nettype none
module idb_detector_chk (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic sample_valid_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [idb_pkg::NCH-1:0] channel_button_output_o,
   input wire logic interrupt_output_o,
   input wire logic [idb_pkg::NCH-1:0][idb_pkg::VW-1:0] channel_processed_value_o
);
   // Lowest value that can ever press: hysteresis only raises the on level
   localparam int PRESS_MIN = 128 * 72;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   irq_or_a: assert property (interrupt_output_o == |channel_button_output_o)
      else $error("interrupt differs from OR of outputs");
   reset_clear_a: assert property ($rose(rst_n_i) |-> !channel_button_output_o)
      else $error("outputs not cleared by reset");
   out_cause_a: assert property ($changed(channel_button_output_o) |-> $past(sample_valid_i, 2))
      else $error("outputs moved without a finished window");
   out_quiet_a: assert property (!sample_valid_i [*2] |=> $stable(channel_button_output_o))
      else $error("outputs moved while no sample arrived");
   value_hold_a: assert property (!sample_valid_i |=> $stable(channel_processed_value_o))
      else $error("value moved without a sample");
   eval_drop_a: assert property (sample_valid_i && ce_i |=> ##1 $stable(channel_processed_value_o))
      else $error("sample in evaluation cycle was taken");
   unmapped_a: assert property (ce_i && reg_addr_i > 8'h2b |=> reg_rdata_o == 8'h00)
      else $error("unmapped register read not zero");
   for (genvar n = 0; n < idb_pkg::NCH; n++) begin : g_ch
      press_level_a: assert property ($rose(channel_button_output_o[n]) |->
         $signed(channel_processed_value_o[n]) >= PRESS_MIN)
         else $error("press below nominal threshold");
   end
endmodule : idb_detector_chk
bind idb_detector idb_detector_chk i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
   .sample_valid_i(sample_valid_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
   .channel_button_output_o(channel_button_output_o), .interrupt_output_o(interrupt_output_o),
   .channel_processed_value_o(channel_processed_value_o));
`default_nettype wire

// ---- tb/idb_coil_model.sv ----
// Sensor coil side: ends sampling windows and hands over counter results
`timescale 1ns/100ps
`default_nettype none
module idb_coil_model (
   input wire logic clk_i,
   output logic sample_valid_o,
   output logic [1:0] sample_channel_o,
   output logic [15:0] sample_count_o
);
   initial begin
      sample_valid_o = 1'b0;
      sample_channel_o = 2'h0;
      sample_count_o = 16'h0000;
   end
   // Idle lines carry the inverse so a stale value is never mistaken for data
   task automatic send(input logic [1:0] ch, input logic [15:0] cnt);
      @(negedge clk_i);
      sample_valid_o = 1'b1;
      sample_channel_o = ch;
      sample_count_o = cnt;
      @(negedge clk_i);
      sample_valid_o = 1'b0;
      sample_channel_o = ~ch;
      sample_count_o = ~cnt;
      repeat (2) @(negedge clk_i);
   endtask : send
endmodule : idb_coil_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the inductive button detector
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [1:0] ch;
      logic [15:0] cnt;
      logic [3:0] btn;
   } idb_row_t;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic ce_i = 1'b1;
   logic normal_power_i = 1'b1;
   logic reg_write_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic sample_valid_i;
   logic [1:0] sample_channel_i;
   logic [15:0] sample_count_i;
   logic [7:0] reg_rdata_o;
   logic [3:0] btn;
   logic irq;
   logic [idb_pkg::NCH-1:0][idb_pkg::VW-1:0] val;
   int n_fail = 0;
   int n_compared = 0;
   logic [31:0] v1;
   logic [7:0] rd;
   logic [31:0] fac [4] = '{32'h1, 32'h4, 32'h8, 32'h10};
   logic [15:0] rst_tab [8] = '{16'h1820, 16'h0c0f, 16'h1500, 16'h1600, 16'h1a00, 16'h2b00,
      16'h4000, 16'h0100};
   // Scaler stays zero: counts near 1000 cannot overflow
   idb_row_t rows [17] = '{
      '{8'h18, 8'h10, 2'h0, 16'h03e8, 4'h0}, '{8'h00, 8'h00, 2'h1, 16'h03e8, 4'h0},
      '{8'h00, 8'h00, 2'h2, 16'h03e8, 4'h0}, '{8'h00, 8'h00, 2'h3, 16'h03e8, 4'h0},
      '{8'h00, 8'h00, 2'h0, 16'h0474, 4'h0}, '{8'h00, 8'h00, 2'h0, 16'h047e, 4'h1},
      '{8'h00, 8'h00, 2'h0, 16'h0460, 4'h1}, '{8'h00, 8'h00, 2'h0, 16'h044c, 4'h0},
      '{8'h16, 8'h03, 2'h0, 16'h04b0, 4'h1}, '{8'h00, 8'h00, 2'h1, 16'h0514, 4'h2},
      '{8'h16, 8'h00, 2'h1, 16'h0514, 4'h3}, '{8'h1a, 8'h03, 2'h1, 16'h0514, 4'h0},
      '{8'h1a, 8'h00, 2'h2, 16'h03e8, 4'h3}, '{8'h19, 8'h8a, 2'h2, 16'h03d9, 4'h0},
      '{8'h19, 8'h00, 2'h2, 16'h03e8, 4'h3}, '{8'h1a, 8'h30, 2'h1, 16'h05dc, 4'h2},
      '{8'h1a, 8'h00, 2'h0, 16'h04b0, 4'h3}};
   idb_detector i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .normal_power_i(normal_power_i), .sample_valid_i(sample_valid_i),
      .sample_channel_i(sample_channel_i), .sample_count_i(sample_count_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
      .reg_rdata_o(reg_rdata_o), .channel_button_output_o(btn),
      .interrupt_output_o(irq), .channel_processed_value_o(val));
   idb_coil_model i_coil (.clk_i(clk_i), .sample_valid_o(sample_valid_i),
      .sample_channel_o(sample_channel_i), .sample_count_o(sample_count_i));
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_write_i = 1'b1;
      @(negedge clk_i);
      reg_write_i = 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      reg_addr_i = a;
      repeat (2) @(negedge clk_i);
      d = reg_rdata_o;
   endtask : reg_rd
   // Two windows of the same count: the value moves by exactly one baseline step
   task automatic trk(input logic [15:0] cnt, input logic [31:0] exp);
      i_coil.send(2'h3, cnt);
      v1 = val[3];
      i_coil.send(2'h3, cnt);
      chk("value step", exp, val[3] - v1);
   endtask : trk
   task automatic conclude;
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (16) @(negedge clk_i);
      rst_n_i = 1'b1;
      foreach (rows[i]) begin
         reg_wr(rows[i].addr, rows[i].wdata);
         i_coil.send(rows[i].ch, rows[i].cnt);
         chk("buttons", {28'h0, rows[i].btn}, {28'h0, btn});
         chk("interrupt", {31'h0, |rows[i].btn}, {31'h0, irq});
      end
      $display("test rows done");
      reg_wr(8'h15, 8'h02);
      for (int q = 0; q < 4; q++) begin
         reg_wr(8'h2b, 8'(q));
         trk(16'h03b6, 32'h4 * fac[q]);
      end
      normal_power_i = 1'b0;
      reg_wr(8'h13, 8'h01);
      reg_wr(8'h2b, 8'h00);
      trk(16'h03b6, 32'h10);
      normal_power_i = 1'b1;
      reg_wr(8'h2b, 8'h03);
      trk(16'h044c, -32'h4);
      reg_wr(8'h16, 8'h80);
      // The hold only starts once the output is up, so press first
      i_coil.send(2'h3, 16'h04b0);
      trk(16'h04b0, 32'h0);
      chk("held button", 32'h1, {31'h0, btn[3]});
      $display("test tracking done");
      @(negedge clk_i);
      rst_n_i = 1'b0;
      repeat (2) @(negedge clk_i);
      chk("outputs in reset", 32'h0, {28'h0, btn});
      rst_n_i = 1'b1;
      foreach (rst_tab[i]) begin
         reg_rd(rst_tab[i][15:8], rd);
         chk("register", {24'h0, rst_tab[i][7:0]}, {24'h0, rd});
      end
      i_coil.send(2'h0, 16'h0514);
      chk("first sample seeds", 32'h0, {28'h0, btn});
      reg_wr(8'h1e, 8'h01);
      i_coil.send(2'h0, 16'h0a28);
      chk("scaled value", 32'h0, val[0]);
      ce_i = 1'b0;
      v1 = val[0];
      i_coil.send(2'h0, 16'h0fff);
      chk("frozen value", v1, val[0]);
      ce_i = 1'b1;
      $display("test reset done");
      conclude();
   end
   // The whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk_i);
      n_fail++;
      $display("timeout");
      conclude();
   end
endmodule : tb_top
`default_nettype wire
